/* File: logic/sar_adc_control.sv */
// The placing of the registers and the strobed register port are this design's own decisions.
module sar_adc_control
    import sar_adc_pkg::*;
(
    input logic clock,
    input logic rst_n,
    input logic [ADDR_W-1:0] reg_addr,
    input logic [DATA_W-1:0] reg_wdata,
    input logic reg_write,
    input logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input logic stop_mode,
    input logic halt_mode,
    input logic compare_high,
    output logic [2:0] analog_inputs_select,
    output logic sample_hold,
    output logic [DATA_W-1:0] dac_code,
    output logic irq
);
    sar_link_if link ();

    logic [2:0] channel_select;
    logic start_conversion;
    logic end_of_conversion;
    logic system_clock_select_bit;
    logic subclock_osc_stop_bit;
    logic irq_done_status;
    logic irq_done_mask;
    logic [3:0] align_count;
    logic run;
    logic align_tick;
    logic begin_conv;
    logic wr_mode;
    logic wr_set;
    logic wr_clr;
    logic [DATA_W-1:0] mode_view;
    logic [DATA_W-1:0] next_rdata;

    sar_step_engine engine
    (
        .clock(clock),
        .rst_n(rst_n),
        .link(link)
    );

    // Subclock oscillator stop bit set, stop mode, or halt while on the subclock
    assign run = !subclock_osc_stop_bit && !stop_mode && !(system_clock_select_bit && halt_mode);
    assign align_tick = run && align_count == ALIGN_LAST;
    assign begin_conv = start_conversion && align_tick;

    assign wr_mode = reg_write && reg_addr == OFF_MODE;
    assign wr_set = reg_write && reg_addr == OFF_MODE_SET;
    assign wr_clr = reg_write && reg_addr == OFF_MODE_CLR;

    assign link.start = begin_conv;
    assign link.run = run;
    assign link.compare_high = compare_high;

    assign mode_view = {1'b0, channel_select, start_conversion, end_of_conversion, 2'b00};

    // Start requests wait for the prescaler so the start point is deterministic
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            align_count <= 4'h0;
        end
        else if (run)
        begin
            align_count <= 4'(align_count + 4'h1);
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_select <= MODE_RESET[CH_MSB:CH_LSB];
        end
        else if (wr_mode)
        begin
            channel_select <= reg_wdata[CH_MSB:CH_LSB];
        end
    end

    // A fresh write of the start bit beats the hardware clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_conversion <= MODE_RESET[SOC_BIT];
        end
        else if (wr_mode)
        begin
            start_conversion <= reg_wdata[SOC_BIT];
        end
        else if (wr_set && reg_wdata[SOC_BIT])
        begin
            start_conversion <= 1'b1;
        end
        else if (wr_clr && reg_wdata[SOC_BIT])
        begin
            start_conversion <= 1'b0;
        end
        else if (begin_conv)
        begin
            start_conversion <= 1'b0;
        end
    end

    // Completion wins over every clear
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            end_of_conversion <= MODE_RESET[EOC_BIT];
        end
        else if (link.done)
        begin
            end_of_conversion <= 1'b1;
        end
        else if (begin_conv)
        begin
            end_of_conversion <= 1'b0;
        end
        else if (wr_mode)
        begin
            end_of_conversion <= reg_wdata[EOC_BIT];
        end
        else if (wr_set && reg_wdata[EOC_BIT])
        begin
            end_of_conversion <= 1'b1;
        end
        else if (wr_clr && reg_wdata[EOC_BIT])
        begin
            end_of_conversion <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_clock_select_bit <= 1'b0;
            subclock_osc_stop_bit <= 1'b0;
        end
        else if (reg_write && reg_addr == OFF_CLOCK)
        begin
            system_clock_select_bit <= reg_wdata[SYSCLK_SEL_BIT];
            subclock_osc_stop_bit <= reg_wdata[SUBCLK_STOP_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_done_mask <= 1'b0;
        end
        else if (reg_write && reg_addr == OFF_IRQ_MASK)
        begin
            irq_done_mask <= reg_wdata[IRQ_DONE_BIT];
        end
    end

    // Read clears the status, but a completion in that cycle survives
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_done_status <= 1'b0;
        end
        else if (link.done)
        begin
            irq_done_status <= 1'b1;
        end
        else if (reg_read && reg_addr == OFF_IRQ_STATUS)
        begin
            irq_done_status <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= irq_done_status && irq_done_mask;
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_read)
        begin
            unique case (reg_addr)
                OFF_MODE: next_rdata = mode_view;
                OFF_RESULT: next_rdata = link.result;
                OFF_CLOCK:
                begin
                    next_rdata[SYSCLK_SEL_BIT] = system_clock_select_bit;
                    next_rdata[SUBCLK_STOP_BIT] = subclock_osc_stop_bit;
                end
                OFF_IRQ_STATUS: next_rdata[IRQ_DONE_BIT] = irq_done_status;
                OFF_IRQ_MASK: next_rdata[IRQ_DONE_BIT] = irq_done_mask;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

    // Channel is latched at start so a later write cannot move the mux mid-conversion
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            analog_inputs_select <= MODE_RESET[CH_MSB:CH_LSB];
        end
        else if (begin_conv)
        begin
            analog_inputs_select <= channel_select;
        end
    end

    // Pin copies of the engine state; the comparator sees them one cycle late,
    // which the 20-cycle bit slot absorbs
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_hold <= 1'b0;
            dac_code <= 8'h00;
        end
        else
        begin
            sample_hold <= link.hold;
            dac_code <= link.trial;
        end
    end
endmodule // sar_adc_control

/* File: logic/sar_adc_pkg.sv */
package sar_adc_pkg;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFF_MODE = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_MODE_SET = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_MODE_CLR = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_CLOCK = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 3'h5;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h6;

    // Mode register fields
    localparam int unsigned CH_LSB = 4;
    localparam int unsigned CH_MSB = 6;
    localparam int unsigned SOC_BIT = 3;
    localparam int unsigned EOC_BIT = 2;
    localparam logic [DATA_W-1:0] MODE_RESET = 8'h04;
    localparam logic [DATA_W-1:0] RESULT_RESET = 8'h7f;

    // Clock control register fields
    localparam int unsigned SYSCLK_SEL_BIT = 0;
    localparam int unsigned SUBCLK_STOP_BIT = 3;

    // Interrupt register fields
    localparam int unsigned IRQ_DONE_BIT = 0;

    // Timing in main oscillator periods; the block clock is the main clock
    localparam int unsigned START_ALIGN_PERIODS = 16;
    localparam int unsigned CONV_PERIODS = 168;
    localparam int unsigned RESULT_BITS = 8;
    localparam int unsigned BIT_PERIODS = 20;
    localparam int unsigned SAMPLE_PERIODS = CONV_PERIODS - RESULT_BITS * BIT_PERIODS;
    localparam logic [3:0] ALIGN_LAST = 4'(START_ALIGN_PERIODS - 1);
    localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_PERIODS - 1);
    localparam logic [4:0] BIT_LAST = 5'(BIT_PERIODS - 1);
    localparam logic [2:0] BIT_TOP = 3'(RESULT_BITS - 1);
    localparam logic [DATA_W-1:0] TRIAL_FIRST = 8'h80;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } sar_state_e;
endpackage

/* File: logic/sar_link_if.sv */
interface sar_link_if;
    logic start;
    logic run;
    logic compare_high;
    logic done;
    logic hold;
    logic [7:0] trial;
    logic [7:0] result;

    modport control
    (
        output start,
        output run,
        output compare_high,
        input done,
        input hold,
        input trial,
        input result
    );

    modport engine
    (
        input start,
        input run,
        input compare_high,
        output done,
        output hold,
        output trial,
        output result
    );
endinterface

/* File: logic/sar_step_engine.sv */
module sar_step_engine
    import sar_adc_pkg::*;
(
    input logic clock,
    input logic rst_n,
    sar_link_if.engine link
);
    sar_state_e state;
    logic [4:0] phase_count;
    logic [2:0] bit_index;
    logic [7:0] next_trial;
    logic phase_end;
    logic last_bit;

    assign phase_end = (state == ST_SAMPLE) ? (phase_count == SAMPLE_LAST) : (phase_count == BIT_LAST);
    assign last_bit = link.run && state == ST_CONVERT && phase_end && bit_index == 3'h0;

    // Decide current bit, then try the next lower one
    always_comb
    begin
        next_trial = link.trial;
        next_trial[bit_index] = link.compare_high;
        if (bit_index != 3'h0)
        begin
            next_trial[3'(bit_index - 3'h1)] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            phase_count <= 5'h00;
            bit_index <= 3'h0;
        end
        else if (link.start)
        begin
            // A new start aborts whatever is running
            state <= ST_SAMPLE;
            phase_count <= 5'h00;
            bit_index <= BIT_TOP;
        end
        else if (link.run)
        begin
            unique case (state)
                ST_IDLE:
                begin
                    phase_count <= 5'h00;
                end
                ST_SAMPLE:
                begin
                    phase_count <= phase_end ? 5'h00 : 5'(phase_count + 5'h01);
                    if (phase_end)
                    begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT:
                begin
                    phase_count <= phase_end ? 5'h00 : 5'(phase_count + 5'h01);
                    if (phase_end && bit_index == 3'h0)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (phase_end)
                    begin
                        bit_index <= 3'(bit_index - 3'h1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.trial <= 8'h00;
            link.hold <= 1'b0;
        end
        else if (link.start)
        begin
            link.trial <= 8'h00;
            link.hold <= 1'b0;
        end
        else if (link.run && phase_end && state == ST_SAMPLE)
        begin
            link.trial <= TRIAL_FIRST;
            link.hold <= 1'b1;
        end
        else if (link.run && phase_end && state == ST_CONVERT)
        begin
            link.trial <= next_trial;
            link.hold <= !last_bit;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.done <= 1'b0;
            link.result <= RESULT_RESET;
        end
        else
        begin
            link.done <= last_bit && !link.start;
            if (last_bit && !link.start)
            begin
                link.result <= next_trial;
            end
        end
    end
endmodule // sar_step_engine

/* File: tb/sar_adc_monitor.sv */
module sar_adc_monitor
    import sar_adc_pkg::*;
(
    input logic clock,
    input logic rst_n,
    input logic [ADDR_W-1:0] reg_addr,
    input logic [DATA_W-1:0] reg_wdata,
    input logic reg_write,
    input logic reg_read,
    input logic [DATA_W-1:0] reg_rdata,
    input logic stop_mode,
    input logic halt_mode,
    input logic [2:0] analog_inputs_select,
    input logic sample_hold,
    input logic [DATA_W-1:0] dac_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_start;
        reg_write && (reg_addr == OFF_MODE || reg_addr == OFF_MODE_SET) && reg_wdata[SOC_BIT];
    endsequence

    sequence s_hold_on;
        $rose(sample_hold);
    endsequence

    a_rdata_idle: assert property (!$past(reg_read) || $past(reg_addr) == 3'h7 |-> reg_rdata == 8'h00)
        else $error("read data not zero outside its slot");
    a_first_trial: assert property (s_hold_on |-> dac_code == 8'h80)
        else $error("first trial code is not the top bit");
    a_trial_steady: assert property (s_hold_on |=> $stable(dac_code)[*8])
        else $error("trial code moved inside a bit slot");
    a_mux_frozen: assert property (sample_hold && $past(sample_hold) |-> $stable(analog_inputs_select))
        else $error("channel changed while holding");
    a_eoc_busy: assert property (reg_read && reg_addr == OFF_MODE && sample_hold |=> !reg_rdata[EOC_BIT])
        else $error("end flag set during conversion");
    a_stop_freeze: assert property (stop_mode && $past(stop_mode) && $past(stop_mode, 2)
        |-> $stable(dac_code) && $stable(sample_hold))
        else $error("converter moved while stopped");
    a_hold_span: assert property (disable iff (!rst_n || stop_mode || halt_mode)
        s_hold_on |-> ##[158:162] $fell(sample_hold))
        else $error("hold phase has wrong length");
    a_start_sample: assert property (disable iff (!rst_n || stop_mode || halt_mode)
        s_start |-> ##[9:26] s_hold_on)
        else $error("conversion did not begin in time");
endmodule // sar_adc_monitor

bind sar_adc_control sar_adc_monitor mon_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .analog_inputs_select(analog_inputs_select),
    .sample_hold(sample_hold), .dac_code(dac_code));

/* File: tb/sar_analog_model.sv */
module sar_analog_model
(
    input wire logic clock,
    input wire logic [2:0] sel,
    input wire logic hold,
    input wire logic [7:0] code,
    input wire logic [7:0] level [8],
    output logic compare_high
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held = 8'h00;
    logic flip = 1'b0;

    always_ff @(posedge clock)
    begin
        flip <= !flip;
        if (!hold)
            held <= level[sel];
    end

    // Output means nothing outside hold, so it wanders
    assign compare_high = hold ? (held >= code) : flip;
endmodule // sar_analog_model

/* File: tb/sar_adc_control_bench.sv */
module sar_adc_control_bench
    import sar_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic stop = 1'b0;
    logic halt = 1'b0;
    logic cmp, hold, irq;
    logic [2:0] sel;
    logic [7:0] rdata, dac;
    logic [7:0] level [8];
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    initial forever #25 clock = ~clock;
    always @(posedge clock) cyc++;

    sar_adc_control dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .stop_mode(stop), .halt_mode(halt),
        .compare_high(cmp), .analog_inputs_select(sel), .sample_hold(hold), .dac_code(dac), .irq(irq));
    sar_analog_model model_u (.clock(clock), .sel(sel), .hold(hold), .code(dac), .level(level),
        .compare_high(cmp));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic [7:0] sar(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--)
            if (v >= (r | (8'h01 << b)))
                r = r | (8'h01 << b);
        return r;
    endfunction

    // Start, look in mid-flight, poll the end flag, then read the result
    task automatic run(input logic [2:0] a, input logic [7:0] w, input logic [2:0] ch,
        input logic [7:0] prev, output int n);
        logic [7:0] d;
        int t0;
        t0 = cyc;
        wr(a, w);
        repeat (30) @(posedge clock);
        rd(OFF_RESULT, d);
        check(d, prev);
        rd(OFF_MODE, d);
        check(d, {1'b0, ch, 4'h0});
        for (int i = 0; i < 400 && d[EOC_BIT] !== 1'b1; i++)
            rd(OFF_MODE, d);
        n = cyc - t0;
        check(d, {1'b0, ch, 4'h4});
        rd(OFF_RESULT, d);
        check(d, sar(level[ch]));
    endtask

    initial
    begin
        #(30000 * 50);
        err_count++;
        give_verdict();
    end

    initial
    begin
        logic [7:0] d;
        logic [7:0] prev;
        int n;
        void'($urandom(49934));
        for (int i = 0; i < 8; i++)
            level[i] = 8'($urandom);
        level[0] = 8'h00;
        level[7] = 8'hff;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFF_MODE, d);
        check(d, MODE_RESET);
        wr(OFF_RESULT, 8'h55);
        rd(OFF_RESULT, d);
        check(d, RESULT_RESET);
        rd(3'h7, d);
        check(d, 8'h00);
        $display("test 1 done");
        prev = RESULT_RESET;
        wr(OFF_IRQ_MASK, 8'h01);
        for (int c = 0; c < 8; c++)
        begin
            run(OFF_MODE, {1'b0, 3'(c), 4'h8}, 3'(c), prev, n);
            check(8'(n >= 171 && n <= 190), 8'h01);
            prev = level[c];
            check(8'(irq), 8'h01);
            rd(OFF_IRQ_STATUS, d);
            check(d, 8'h01);
            @(posedge clock);
            #1 check(8'(irq), 8'h00);
        end
        $display("test 2 done");
        wr(OFF_IRQ_MASK, 8'h00);
        wr(OFF_MODE, 8'h24);
        wr(OFF_MODE_CLR, 8'h04);
        rd(OFF_MODE, d);
        check(d, 8'h20);
        // Stop lands inside the hold phase, so the count must stretch
        fork
            begin
                repeat (60) @(posedge clock);
                stop <= 1'b1;
                repeat (100) @(posedge clock);
                stop <= 1'b0;
            end
        join_none
        run(OFF_MODE_SET, 8'h08, 3'h2, prev, n);
        check(8'(n >= 271), 8'h01);
        check(8'(irq), 8'h00);
        $display("test 3 done");
        prev = level[2];
        wr(OFF_CLOCK, 8'h09);
        rd(OFF_CLOCK, d);
        check(d, 8'h09);
        wr(OFF_CLOCK, 8'h01);
        // Halt freezes the converter only while the subclock is selected
        fork
            begin
                repeat (60) @(posedge clock);
                halt <= 1'b1;
                repeat (100) @(posedge clock);
                halt <= 1'b0;
            end
        join_none
        run(OFF_MODE, 8'h58, 3'h5, prev, n);
        check(8'(n >= 271), 8'h01);
        wr(OFF_CLOCK, 8'h00);
        wr(OFF_MODE_CLR, 8'h04);
        rd(OFF_MODE, d);
        check(d, 8'h50);
        wr(OFF_MODE_SET, 8'h04);
        rd(OFF_MODE, d);
        check(d, 8'h54);
        $display("test 4 done");
        give_verdict();
    end
endmodule // sar_adc_control_bench
